// [rtl/enc_cfg_defines.svh]
/*
 Offsets, field positions, reset values and timing counts of the encoder
 switch configuration block.
 Assumes inclusion by its bare name from the design files.
*/
`ifndef ENC_CFG_DEFINES_SVH
`define ENC_CFG_DEFINES_SVH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define CFG_CTRL_ADDR 12'h000
`define CFG_STAT_ADDR 12'h004
`define CFG_GAIN_ADDR 12'h008
`define CFG_PROC_ADDR 12'h00c
`define CFG_SYNC_ADDR 12'h010

// ****************************************************************
// Selector positions and steps.
// ****************************************************************
`define POS_STD_AUTO 4'h0
`define POS_STD_LINES 4'h1
`define POS_SETUP 4'h2
`define POS_SUBCAR 4'h3
`define POS_GAIN 4'h4
`define POS_USER 4'h5
`define POS_LUMA 4'h6
`define POS_BLACK 4'h7
`define POS_CHROMA 4'h8
`define POS_HUE 4'h9
`define POS_CHR_EN 4'ha
`define POS_BURST_EN 4'hb
`define POS_VI_PASS 4'hc
`define POS_L21 4'hd
`define POS_L22 4'he
`define POS_RECALL 4'hf
`define POS2_LOCK 4'h0
`define POS2_FRZ_REC 4'h4
`define POS2_FRZ_MAN 4'h5
`define POS2_FRZ_MODE 4'h6
`define POS2_FRZ_FIELD 4'h7
`define POS2_FRZ_SIG 4'h8
`define POS2_XCOLOR 4'ha
`define POS2_TST_SEL 4'hc
`define POS2_TST_EN 4'hd
`define POS2_VI_SETUP 4'hf

// ****************************************************************
// Level defaults, limits and timing.
// ****************************************************************
`define LEVEL_MID 8'h80
`define LEVEL_MAX 8'hff
`define LEVEL_MIN 8'h00
`define PEDESTAL_MV 54
`define CLK_PERIOD_NS 8
`define CONFIGURING_INDICATOR_TIME_NS 80
`define CONFIGURING_INDICATOR_CYCLES (`CONFIGURING_INDICATOR_TIME_NS / `CLK_PERIOD_NS)

`endif

// [rtl/enc_cfg_pkg.sv]
/*
 Types of the encoder switch configuration block.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package enc_cfg_pkg;
   typedef enum logic [1:0] {PADDLE_IDLE, PADDLE_APPLY, PADDLE_HOLD}
      paddle_state_type;
endpackage
`default_nettype wire

// [rtl/enc_cfg.sv]
/*
 Switch-driven configuration and setup-insertion control of a video
 encoder, with an AXI4-Lite slave that mirrors the settings other than l21 and l22 and drives the eight control-register bits.
 Assumes the selector and paddle inputs are debounced and synchronous to
 i_ref_clk, and that one bus write or read is under way at a time.
*/
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`include "enc_cfg_defines.svh"
`default_nettype none

// Contract
// - Master setup overrides all other setup controls.
// - Setup on, 525: pedestal on full field; the code also requires vi_setup (bank two F) for it.
// - Setup off: no pedestal on any line.
// - Setup on: line 21, 22, interval removable.
// - Bank one D, E toggle lines 21, 22.
// - Bank two F toggles interval pedestal.
// - Default: picture on, interval off, 21 off, 22 on.
// - Position zero auto/manual; one picks lines.
// - Master setup ignored in 625-line standard.
// - Position three subcarrier, ignored at 625.
// - Position four gain, 256 steps.
// - Luma, chroma levels, 256 steps each.
// - Black level, 256 steps.
// - Hue full rotation, disabled in PAL.
// - Calibrated mode forces processing presets.
// - Chroma, burst enables; interval pass/delete.
// - Paddle down at F recalls defaults.
// - Video lock source forces delay mode.
// - Auto freeze holds last field on loss.
// - Freeze output last field or black.
// - Test mode replaces input with pattern.
// - Synchronizer controls inactive without submodule.
// - Two banks of sixteen; paddle applies setting.
module enc_cfg (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   // Switches and status inputs.
   input wire logic i_bank_two,
   input wire logic [3:0] i_position,
   input wire logic i_paddle_up,
   input wire logic i_paddle_down,
   input wire logic i_detected_625,
   input wire logic i_sync_present,
   input wire logic i_reference_present,
   input wire logic i_input_lost,
   // AXI4-Lite slave.
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Indicators.
   output logic o_second_bank_indicator,
   output logic o_configuring_indicator,
   // Setup insertion per region.
   output logic o_active_picture_region,
   output logic o_vertical_interval_region,
   output logic o_full_field_region,
   output logic o_line21_setup,
   output logic o_line22_setup,
   // Effective video settings.
   output logic o_std_625,
   output logic o_pal_m,
   output logic [7:0] o_gain,
   output logic [7:0] o_luma,
   output logic [7:0] o_black,
   output logic [7:0] o_chroma,
   output logic [7:0] o_hue,
   output logic o_chroma_en,
   output logic o_burst_en,
   output logic o_vi_pass,
   output logic o_cross_color_en,
   output logic o_test_en,
   output logic o_test_linearity,
   // Synchronizer settings.
   output logic o_delay_mode,
   output logic o_freeze_active,
   output logic o_freeze_field_mode,
   output logic o_freeze_field_two,
   output logic o_freeze_black
);

   // ****************************************************************
   // Settings.
   // ****************************************************************
   enc_cfg_pkg::paddle_state_type paddle_state;
   logic std_auto, man_625, setup_on, pal_m, user_enable;
   logic chr_en, burst_en, vi_pass, l21, l22, vi_setup;
   logic lock_video, frz_auto, frz_manual, frz_field_mode, frz_field2;
   logic frz_black, xcolor, tst_linearity, tst_en;
   logic [7:0] gain, luma, black, chroma, hue;
   logic [7:0] configuring_indicator_count;
   logic up, down, act, std_625, recall;
   logic wr_go, aw_full, w_full, w_strb;
   logic [11:0] aw_addr;
   logic [31:0] w_data;

   // Paddle actuation yields one apply pulse per press.
   assign act = paddle_state == enc_cfg_pkg::PADDLE_APPLY;
   assign up = act & i_paddle_up;
   assign down = act & i_paddle_down;
   assign recall = down & ~i_bank_two & i_position == `POS_RECALL;
   assign std_625 = std_auto ? i_detected_625 : man_625;
   assign wr_go = aw_full & w_full & ~s_axi_bvalid;

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         paddle_state <= enc_cfg_pkg::PADDLE_IDLE;
      end else begin
         case (paddle_state)
            enc_cfg_pkg::PADDLE_IDLE:
               if (i_paddle_up ^ i_paddle_down) begin
                  paddle_state <= enc_cfg_pkg::PADDLE_APPLY;
               end
            enc_cfg_pkg::PADDLE_APPLY:
               paddle_state <= enc_cfg_pkg::PADDLE_HOLD;
            enc_cfg_pkg::PADDLE_HOLD:
               if (!i_paddle_up && !i_paddle_down) begin
                  paddle_state <= enc_cfg_pkg::PADDLE_IDLE;
               end
            default: paddle_state <= enc_cfg_pkg::PADDLE_IDLE;
         endcase
      end
   end

   // Saturating one-step move of a level.
   function automatic logic [7:0] step(input logic [7:0] v,
                                       input logic inc, input logic dec);
      logic [7:0] r;
      r = v;
      if (inc && v != `LEVEL_MAX) begin
         r = v + 8'h01;
      end else if (dec && v != `LEVEL_MIN) begin
         r = v - 8'h01;
      end
      return r;
   endfunction

   // ****************************************************************
   // Bank one and bank two settings, switch and bus writes.
   // ****************************************************************
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         std_auto <= 1'b1;
         man_625 <= 1'b0;
         setup_on <= 1'b1;
         pal_m <= 1'b0;
         user_enable <= 1'b0;
         chr_en <= 1'b1;
         burst_en <= 1'b1;
         vi_pass <= 1'b1;
         l21 <= 1'b0;
         l22 <= 1'b1;
         vi_setup <= 1'b0;
         lock_video <= 1'b0;
         frz_auto <= 1'b0;
         frz_manual <= 1'b0;
         frz_field_mode <= 1'b0;
         frz_field2 <= 1'b0;
         frz_black <= 1'b0;
         xcolor <= 1'b0;
         tst_linearity <= 1'b0;
         tst_en <= 1'b0;
         gain <= `LEVEL_MID;
         luma <= `LEVEL_MID;
         black <= `LEVEL_MID;
         chroma <= `LEVEL_MID;
         hue <= `LEVEL_MID;
      end else if (recall) begin
         std_auto <= 1'b1;
         man_625 <= 1'b0;
         setup_on <= 1'b1;
         pal_m <= 1'b0;
         user_enable <= 1'b0;
         chr_en <= 1'b1;
         burst_en <= 1'b1;
         vi_pass <= 1'b1;
         l21 <= 1'b0;
         l22 <= 1'b1;
         vi_setup <= 1'b0;
         gain <= `LEVEL_MID;
         luma <= `LEVEL_MID;
         black <= `LEVEL_MID;
         chroma <= `LEVEL_MID;
         hue <= `LEVEL_MID;
      end else if (wr_go && aw_addr == `CFG_CTRL_ADDR && w_strb) begin
         std_auto <= w_data[0];
         man_625 <= w_data[1];
         setup_on <= w_data[2];
         pal_m <= w_data[3];
         user_enable <= w_data[4];
         chr_en <= w_data[5];
         burst_en <= w_data[6];
         vi_pass <= w_data[7];
      end else if (act && !i_bank_two) begin
         case (i_position)
            `POS_STD_AUTO: std_auto <= up;
            `POS_STD_LINES: if (!std_auto) man_625 <= down;
            `POS_SETUP: if (!std_625) setup_on <= up;
            `POS_SUBCAR: if (!std_625) pal_m <= down;
            `POS_GAIN: gain <= step(gain, up, down);
            `POS_USER: user_enable <= up;
            `POS_LUMA: if (user_enable) luma <= step(luma, up, down);
            `POS_BLACK: if (user_enable) black <= step(black, up, down);
            `POS_CHROMA: if (user_enable) chroma <= step(chroma, up, down);
            `POS_HUE: if (user_enable && !std_625 && !pal_m) begin
               hue <= hue + {7'h00, up} - {7'h00, down};
            end
            `POS_CHR_EN: chr_en <= up;
            `POS_BURST_EN: burst_en <= up;
            `POS_VI_PASS: vi_pass <= up;
            `POS_L21: l21 <= up;
            `POS_L22: l22 <= up;
            default: ;
         endcase
      end else if (act && i_bank_two) begin
         case (i_position)
            `POS2_LOCK: lock_video <= up;
            `POS2_FRZ_REC: if (i_sync_present) frz_auto <= down;
            `POS2_FRZ_MAN: if (i_sync_present) frz_manual <= down;
            `POS2_FRZ_MODE: if (i_sync_present) frz_field_mode <= down;
            `POS2_FRZ_FIELD: if (i_sync_present) frz_field2 <= down;
            `POS2_FRZ_SIG: if (i_sync_present) frz_black <= down;
            `POS2_XCOLOR: xcolor <= up;
            `POS2_TST_SEL: tst_linearity <= down;
            `POS2_TST_EN: tst_en <= up;
            `POS2_VI_SETUP: vi_setup <= up;
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Effective outputs.
   // ****************************************************************
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_second_bank_indicator <= 1'b0;
         o_active_picture_region <= 1'b0;
         o_vertical_interval_region <= 1'b0;
         o_full_field_region <= 1'b0;
         o_line21_setup <= 1'b0;
         o_line22_setup <= 1'b0;
         o_std_625 <= 1'b0;
         o_pal_m <= 1'b0;
         o_gain <= `LEVEL_MID;
         o_luma <= `LEVEL_MID;
         o_black <= `LEVEL_MID;
         o_chroma <= `LEVEL_MID;
         o_hue <= `LEVEL_MID;
         o_chroma_en <= 1'b0;
         o_burst_en <= 1'b0;
         o_vi_pass <= 1'b0;
         o_cross_color_en <= 1'b0;
         o_test_en <= 1'b0;
         o_test_linearity <= 1'b0;
         o_delay_mode <= 1'b0;
         o_freeze_active <= 1'b0;
         o_freeze_field_mode <= 1'b0;
         o_freeze_field_two <= 1'b0;
         o_freeze_black <= 1'b0;
      end else begin
         o_second_bank_indicator <= i_bank_two;
         // Setup gating: master off or 625 clears every region.
         o_active_picture_region <= setup_on & ~std_625;
         o_vertical_interval_region <= setup_on & ~std_625 & vi_setup;
         o_full_field_region <= setup_on & ~std_625 & vi_setup;
         o_line21_setup <= setup_on & ~std_625 & l21;
         o_line22_setup <= setup_on & ~std_625 & l22;
         o_std_625 <= std_625;
         o_pal_m <= pal_m & ~std_625;
         o_gain <= gain;
         o_luma <= user_enable ? luma : `LEVEL_MID;
         o_black <= user_enable ? black : `LEVEL_MID;
         o_chroma <= user_enable ? chroma : `LEVEL_MID;
         o_hue <= (user_enable && !std_625 && !pal_m) ? hue : `LEVEL_MID;
         o_chroma_en <= chr_en;
         o_burst_en <= burst_en;
         o_vi_pass <= vi_pass;
         o_cross_color_en <= xcolor;
         o_test_en <= tst_en;
         o_test_linearity <= tst_linearity;
         o_delay_mode <= i_sync_present &
                         (lock_video | ~i_reference_present);
         o_freeze_active <= i_sync_present &
                            (frz_manual | (frz_auto & i_input_lost));
         o_freeze_field_mode <= i_sync_present & frz_field_mode;
         o_freeze_field_two <= i_sync_present & frz_field2;
         o_freeze_black <= i_sync_present & frz_black;
      end
   end

   // Configuring indicator stretched after each applied setting.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         configuring_indicator_count <= 8'h00;
         o_configuring_indicator <= 1'b1;
      end else begin
         if (act || wr_go) begin
            configuring_indicator_count <= 8'(`CONFIGURING_INDICATOR_CYCLES);
         end else if (configuring_indicator_count != 8'h00) begin
            configuring_indicator_count <= configuring_indicator_count - 8'h01;
         end
         o_configuring_indicator <= act | wr_go | (configuring_indicator_count != 8'h00);
      end
   end

   // ****************************************************************
   // AXI4-Lite slave.
   // ****************************************************************
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h0000_0000;
         w_strb <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         s_axi_awready <= ~aw_full & ~s_axi_awready;
         s_axi_wready <= ~w_full & ~s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == `CFG_CTRL_ADDR) ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
               `CFG_CTRL_ADDR: s_axi_rdata <= {24'h0, vi_pass, burst_en,
                  chr_en, user_enable, pal_m, setup_on, man_625, std_auto};
               `CFG_STAT_ADDR: s_axi_rdata <= {27'h0, o_freeze_active,
                  o_delay_mode, i_sync_present, o_configuring_indicator,
                  std_625};
               `CFG_GAIN_ADDR: s_axi_rdata <= {24'h0, gain};
               `CFG_PROC_ADDR: s_axi_rdata <= {hue, chroma, black, luma};
               `CFG_SYNC_ADDR: s_axi_rdata <= {22'h0, tst_en, tst_linearity,
                  xcolor, frz_black, frz_field2, frz_field_mode, frz_manual,
                  frz_auto, lock_video, vi_setup};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   property p_master_off;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      !setup_on |=> !o_line21_setup && !o_line22_setup &&
                    !o_vertical_interval_region;
   endproperty
   a_master_off: assert property (p_master_off)
      else $error("Pedestal present with master setup off.");

   property p_625_no_setup;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      std_625 |=> !o_active_picture_region;
   endproperty
   a_625_no_setup: assert property (p_625_no_setup)
      else $error("Setup applied in 625 standard.");

   property p_gain_sat;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      gain == `LEVEL_MAX && !recall && !down |=> gain == `LEVEL_MAX;
   endproperty
   a_gain_sat: assert property (p_gain_sat)
      else $error("Gain wrapped past maximum.");

   property p_one_step;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      paddle_state == enc_cfg_pkg::PADDLE_APPLY |=>
         paddle_state != enc_cfg_pkg::PADDLE_APPLY;
   endproperty
   a_one_step: assert property (p_one_step)
      else $error("Paddle applied twice in one press.");

   property p_calibrated;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      !user_enable |=> o_luma == `LEVEL_MID && o_chroma == `LEVEL_MID;
   endproperty
   a_calibrated: assert property (p_calibrated)
      else $error("User levels active in calibrated mode.");

   property p_recall;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      recall |=> gain == `LEVEL_MID && l22 && !l21 && setup_on;
   endproperty
   a_recall: assert property (p_recall)
      else $error("Recall did not restore defaults.");

   property p_video_lock;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      lock_video && i_sync_present |=> o_delay_mode;
   endproperty
   a_video_lock: assert property (p_video_lock)
      else $error("Video lock did not force delay mode.");

   property p_no_sync;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      !i_sync_present |=> !o_freeze_active && !o_delay_mode;
   endproperty
   a_no_sync: assert property (p_no_sync)
      else $error("Synchronizer control active without submodule.");

   property p_auto_freeze;
      @(posedge i_ref_clk) disable iff (!i_resetn)
      frz_auto && i_sync_present && i_input_lost |=> o_freeze_active;
   endproperty
   a_auto_freeze: assert property (p_auto_freeze)
      else $error("Auto freeze missed input loss.");

endmodule // enc_cfg
`default_nettype wire

// [tb/enc_cfg_tb.sv]
/*
 Self-checking bench of the encoder switch configuration block.
 Assumes the design files are compiled first and a 125 MHz clock.
*/
`default_nettype none
module enc_cfg_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // Signals.
   // ****************************************************************
   logic i_ref_clk, i_resetn, i_bank_two, i_paddle_up, i_paddle_down;
   logic [3:0] i_position;
   logic i_sync_present, i_reference_present, i_detected_625, i_input_lost;
   logic frz;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] o_gain, o_luma, o_black;
   logic ap, vi, ff, l21, l22, s625, palm, chr, bur, tst, dly, sbi;
   logic [11:0] flags;
   logic [11:0] ce;
   logic [11:0] eq[$];
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int miscompares = 0;
   int num_checks = 0;
   int seed = 18569;
   int k;
   event smp;
   assign flags = {sbi, dly, tst, bur, chr, palm, s625, ff, l22, l21, vi, ap};

   enc_cfg enc_cfg_inst (.i_ref_clk, .i_resetn, .i_bank_two, .i_position,
      .i_paddle_up, .i_paddle_down, .i_detected_625, .i_sync_present,
      .i_reference_present, .i_input_lost, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .o_second_bank_indicator(sbi), .o_configuring_indicator(),
      .o_active_picture_region(ap), .o_vertical_interval_region(vi),
      .o_full_field_region(ff), .o_line21_setup(l21), .o_line22_setup(l22),
      .o_std_625(s625), .o_pal_m(palm), .o_gain, .o_luma, .o_black,
      .o_chroma(), .o_hue(), .o_chroma_en(chr), .o_burst_en(bur),
      .o_vi_pass(), .o_cross_color_en(), .o_test_en(tst),
      .o_test_linearity(), .o_delay_mode(dly), .o_freeze_active(frz),
      .o_freeze_field_mode(), .o_freeze_field_two(), .o_freeze_black());

   // ****************************************************************
   // Checking.
   // ****************************************************************
   function automatic logic [7:0] act(input logic [3:0] s);
      act = s < 4'hc ? {7'h00, flags[s]} : s == 4'hc ? o_gain :
         s == 4'hd ? o_black : s == 4'he ? o_luma : {7'h00, frz};
   endfunction
   task automatic results;
      if (miscompares == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic timeout;
      miscompares++;
      results();
   endtask
   task automatic check_val(input logic [3:0] s, input logic [7:0] e);
      num_checks++;
      if (act(s) !== e) begin
         miscompares++;
         $display("Error at %0t: output %0d is %h not %h", $time, s,
            act(s), e);
      end
   endtask
   task automatic check_bus(input logic [33:0] e, input logic [33:0] a);
      num_checks++;
      if (a !== e) begin
         miscompares++;
         $display("Error at %0t: bus answer %h not %h", $time, a, e);
      end
   endtask
   always @(smp) begin
      ce = eq.pop_front();
      check_val(ce[11:8], ce[7:0]);
   end
   always @(posedge i_ref_clk) begin
      if (s_axi_bvalid && s_axi_bready)
         check_bus({32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
      if (s_axi_rvalid && s_axi_rready)
         check_bus(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
   end

   // ****************************************************************
   // Drivers.
   // ****************************************************************
   task automatic expect_out(input logic [3:0] s, input logic [7:0] v);
      @(negedge i_ref_clk);
      eq.push_back({s, v});
      ->smp;
   endtask
   task automatic press(input logic b, input logic [3:0] p, input logic up);
      @(posedge i_ref_clk);
      i_bank_two <= b;
      i_position <= p;
      repeat (2) @(posedge i_ref_clk);
      i_paddle_up <= up;
      i_paddle_down <= !up;
      repeat (3) @(posedge i_ref_clk);
      i_paddle_up <= 1'b0;
      i_paddle_down <= 1'b0;
      repeat (14) @(posedge i_ref_clk);
   endtask
   task automatic step(input logic b, input logic [3:0] p, input logic up,
      input logic [3:0] s, input logic [7:0] v);
      press(b, p, up);
      expect_out(s, v);
   endtask
   task automatic axi_wr(input logic [11:0] a, input logic [1:0] r);
      int n;
      @(posedge i_ref_clk);
      bq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= $random(seed);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50 && !s_axi_bvalid; n++) begin
         @(posedge i_ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      if (n >= 50) timeout();
   endtask
   task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
      int n;
      @(posedge i_ref_clk);
      rq.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
         @(posedge i_ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      if (n >= 50) timeout();
   endtask

   // ****************************************************************
   // Clock and main sequence.
   // ****************************************************************
   initial begin
      i_ref_clk = 1'b0;
      forever #4 i_ref_clk = ~i_ref_clk;
   end
   initial begin
      {i_resetn, i_bank_two, i_paddle_up, i_paddle_down, i_position} = '0;
      {i_sync_present, i_reference_present, s_axi_awaddr} = '1;
      {i_detected_625, i_input_lost} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_wdata} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      repeat (3) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      expect_out(4'h0, 8'h01);
      expect_out(4'h1, 8'h00);
      expect_out(4'h2, 8'h00);
      expect_out(4'h3, 8'h01);
      step(1'b0, 4'hd, 1'b1, 4'h2, 8'h01);
      step(1'b0, 4'he, 1'b0, 4'h3, 8'h00);
      step(1'b1, 4'hf, 1'b1, 4'h1, 8'h01);
      expect_out(4'h4, 8'h01);
      expect_out(4'hb, 8'h01);
      step(1'b0, 4'h2, 1'b0, 4'h0, 8'h00);
      expect_out(4'h1, 8'h00);
      step(1'b0, 4'hd, 1'b1, 4'h2, 8'h00);
      step(1'b0, 4'h2, 1'b1, 4'h1, 8'h01);
      step(1'b0, 4'ha, 1'b0, 4'h7, 8'h00);
      step(1'b0, 4'hb, 1'b1, 4'h8, 8'h01);
      step(1'b1, 4'hd, 1'b1, 4'h9, 8'h01);
      step(1'b1, 4'h0, 1'b1, 4'ha, 8'h01);
      k = 1 + ($unsigned($random(seed)) % 4);
      repeat (k) press(1'b0, 4'h4, 1'b1);
      expect_out(4'hc, 8'h80 + k[7:0]);
      step(1'b0, 4'hf, 1'b0, 4'hc, 8'h80);
      @(posedge i_ref_clk);
      i_detected_625 <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      expect_out(4'h5, 8'h01);
      press(1'b0, 4'h5, 1'b1);
      step(1'b0, 4'h6, 1'b1, 4'he, 8'h81);
      repeat (130) press(1'b0, 4'h7, 1'b0);
      expect_out(4'hd, 8'h00);
      step(1'b0, 4'h5, 1'b0, 4'he, 8'h80);
      press(1'b0, 4'h0, 1'b0);
      step(1'b0, 4'h1, 1'b0, 4'h5, 8'h01);
      expect_out(4'h0, 8'h00);
      step(1'b0, 4'h3, 1'b0, 4'h6, 8'h00);
      step(1'b1, 4'h4, 1'b0, 4'hf, 8'h00);
      @(posedge i_ref_clk);
      i_input_lost <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      expect_out(4'hf, 8'h01);
      @(posedge i_ref_clk);
      i_sync_present <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      expect_out(4'hf, 8'h00);
      expect_out(4'ha, 8'h00);
      axi_rd(12'h004, {2'h0, 32'h0000_0001});
      axi_rd(12'h100, {2'h2, 32'h0});
      axi_wr(12'h008, 2'h2);
      expect_out(4'hc, 8'h80);
      repeat (4) @(posedge i_ref_clk);
      results();
   end
endmodule // enc_cfg_tb
`default_nettype wire
